// file: hw/ssrb_regs.svh
// Register map, status bit positions and limits of the scale status bank
// Functional notes
// - Status bit 0: net weight exceeds one register
// - Status bit 1: gross weight exceeds one register
// - Status bit 2: flow rate exceeds one register
// - Bits 3,4,5: good zero display, gross, net
// - Bit 6 net mode, bit 7 motion
// - Bit 11: flow rate shown on display
// - Bit 12: net weight beyond six digits
// - Bit 13: gross weight beyond six digits
// - Gross weight register, valid with error zero
// - Net weight register, valid with error zero
// - Flow rate register, valid with error zero
// - Input signal in mV/V readable per scale
// - Four analog output values mirrored readable
// - Inputs 11-18, 21-28 into word one
// - Inputs 31-38, 41-48 into word two
// - Inputs 51-58, 61-68 into word three
// - Error code zero when healthy, 0..255
`ifndef SSRB_REGS_SVH
`define SSRB_REGS_SVH
`define SSRB_NSCALE        8
`define SSRB_NAOUT         4
`define SSRB_NDIN          48
`define SSRB_OFF_STATUS    3'h0
`define SSRB_OFF_GROSS     3'h1
`define SSRB_OFF_NET       3'h2
`define SSRB_OFF_FLOW      3'h3
`define SSRB_OFF_SIGNAL    3'h4
`define SSRB_OFF_ERROR     3'h5
`define SSRB_ANALOG_BASE   8'h40
`define SSRB_DIN_W0        8'h44
`define SSRB_DIN_W1        8'h45
`define SSRB_DIN_W2        8'h46
`define SSRB_BIT_NETOVF    0
`define SSRB_BIT_GROSSOVF  1
`define SSRB_BIT_FLOWOVF   2
`define SSRB_BIT_GZDISP    3
`define SSRB_BIT_GZGROSS   4
`define SSRB_BIT_GZNET     5
`define SSRB_BIT_NETMODE   6
`define SSRB_BIT_MOTION    7
`define SSRB_BIT_FLOWDISP  11
`define SSRB_BIT_NETPREC   12
`define SSRB_BIT_GROSSPREC 13
`define SSRB_UNUSED_MASK   16'hc700
`define SSRB_SIX_DIGIT_MAX 32'sh000f423f
`define SSRB_RESET_WORD    16'h0000
`endif

// file: hw/ssrb_pkg.sv
// Types shared by the scale status bank and its users
`default_nettype none
package ssrb_pkg;
  // One scale's live values from the weighing engine
  typedef struct packed {
    logic signed [31:0] net;       // Net weight, scaled integer
    logic signed [31:0] gross;     // Gross weight, scaled integer
    logic signed [31:0] flow;      // Flow rate, scaled integer
    logic [15:0]        inSignal;  // Load cell signal, mV/V scaled
    logic [7:0]         errCode;   // Scale error code, zero when healthy
    logic               gzDisp;    // Good zero on displayed weight
    logic               gzGross;   // Good zero on gross
    logic               gzNet;     // Good zero on net
    logic               netMode;   // Net mode selected
    logic               motion;    // Weight unstable
    logic               flowShown; // Display shows flow rate
  } ssrb_scale_t;
  // Register request from the protocol engine
  typedef struct packed {
    logic       valid; // Request present this cycle
    logic       write; // Write attempt
    logic [7:0] addr;  // Register index
  } ssrb_req_t;
  // Answer one cycle later
  typedef struct packed {
    logic        valid; // Answer present
    logic        err;   // Illegal address or write
    logic [15:0] data;  // Read data
  } ssrb_rsp_t;
endpackage
`default_nettype wire

// file: hw/ssrb_bank.sv
// Read-only register bank for the per-scale status, weights and I/O state
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_regs.svh"
module ssrb_bank (
  input  wire logic                 clk,                        // 100 MHz clock
  input  wire logic                 rst_n,                      // Sync reset, low
  input  wire ssrb_pkg::ssrb_scale_t scaleIn [`SSRB_NSCALE],    // Live scale data
  input  wire logic [15:0]          aoutVal [`SSRB_NAOUT],      // Analog out values
  input  wire logic [47:0]          digIn,                      // Input pins, async
  input  wire ssrb_pkg::ssrb_req_t  req,                        // Register request
  output var ssrb_pkg::ssrb_rsp_t   rsp                         // Registered answer
);
  import ssrb_pkg::*;

  // True when a 32-bit value fits a signed 16-bit register
  function automatic logic ssrbFits16(input logic signed [31:0] v);
    return (v[31:15] == 17'h00000) || (v[31:15] == 17'h1ffff);
  endfunction

  // True when magnitude passes six decimal digits
  function automatic logic ssrbOver6(input logic signed [31:0] v);
    return (v > `SSRB_SIX_DIGIT_MAX) || (v < -`SSRB_SIX_DIGIT_MAX);
  endfunction

  // Saturate so a master never sees a wrapped weight
  function automatic logic [15:0] ssrbSat16(input logic signed [31:0] v);
    if (ssrbFits16(v)) begin
      return v[15:0];
    end
    return v[31] ? 16'h8000 : 16'h7fff;
  endfunction

  // Build one status word; unused bits stay zero
  function automatic logic [15:0] ssrbStatus(input ssrb_scale_t sc);
    logic [15:0] w;
    w = `SSRB_RESET_WORD;
    w[`SSRB_BIT_NETOVF]    = !ssrbFits16(sc.net);
    w[`SSRB_BIT_GROSSOVF]  = !ssrbFits16(sc.gross);
    w[`SSRB_BIT_FLOWOVF]   = !ssrbFits16(sc.flow);
    w[`SSRB_BIT_GZDISP]    = sc.gzDisp;
    w[`SSRB_BIT_GZGROSS]   = sc.gzGross;
    w[`SSRB_BIT_GZNET]     = sc.gzNet;
    w[`SSRB_BIT_NETMODE]   = sc.netMode;
    w[`SSRB_BIT_MOTION]    = sc.motion;
    w[`SSRB_BIT_FLOWDISP]  = sc.flowShown;
    w[`SSRB_BIT_NETPREC]   = ssrbOver6(sc.net);
    w[`SSRB_BIT_GROSSPREC] = ssrbOver6(sc.gross);
    return w;
  endfunction

  // Snapshot storage, one word per register
  logic [15:0] statusReg [`SSRB_NSCALE]; // Status words
  logic [15:0] grossReg  [`SSRB_NSCALE]; // Gross weights
  logic [15:0] netReg    [`SSRB_NSCALE]; // Net weights
  logic [15:0] flowReg   [`SSRB_NSCALE]; // Flow rates
  logic [15:0] sigReg    [`SSRB_NSCALE]; // Input signals
  logic [7:0]  errReg    [`SSRB_NSCALE]; // Error codes
  logic [15:0] aoutReg   [`SSRB_NAOUT];  // Analog mirrors
  logic [47:0] digMeta;                  // First sync stage
  logic [47:0] digSync;                  // Second sync stage
  ssrb_rsp_t   next_rsp;                 // Answer being built

  // One clock domain, so every assertion below shares this clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Input pins cross into the clock domain through two flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      digMeta <= 48'h000000000000;
      digSync <= 48'h000000000000;
    end else begin
      digMeta <= digIn;
      digSync <= digMeta;
    end
  end

  // Per-scale snapshot; all fields move on the same edge so one
  // read never mixes two samples of the same scale
  for (genvar s = 0; s < `SSRB_NSCALE; s++) begin : g_scale
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        statusReg[s] <= `SSRB_RESET_WORD;
        grossReg[s]  <= `SSRB_RESET_WORD;
        netReg[s]    <= `SSRB_RESET_WORD;
        flowReg[s]   <= `SSRB_RESET_WORD;
        sigReg[s]    <= `SSRB_RESET_WORD;
        errReg[s]    <= 8'h00;
      end else begin
        statusReg[s] <= ssrbStatus(scaleIn[s]);
        grossReg[s]  <= ssrbSat16(scaleIn[s].gross);
        netReg[s]    <= ssrbSat16(scaleIn[s].net);
        flowReg[s]   <= ssrbSat16(scaleIn[s].flow);
        sigReg[s]    <= scaleIn[s].inSignal;
        errReg[s]    <= scaleIn[s].errCode;
      end
    end

    // Overflow flags follow their value one edge later; the first edge
    // out of reset still shows the reset word, so it is skipped
    a_net_ovf: assert property (
      $past(rst_n) |->
        statusReg[s][`SSRB_BIT_NETOVF] == !ssrbFits16($past(scaleIn[s].net)))
      else $error("net overflow flag wrong");
    a_gross_ovf: assert property (
      $past(rst_n) |->
        statusReg[s][`SSRB_BIT_GROSSOVF] == !ssrbFits16($past(scaleIn[s].gross)))
      else $error("gross overflow flag wrong");
    a_flow_ovf: assert property (
      !ssrbFits16(scaleIn[s].flow) |=> statusReg[s][`SSRB_BIT_FLOWOVF])
      else $error("flow overflow flag missed");
    // Good zero bits track their sources
    a_good_zero: assert property (
      $past(rst_n) |-> statusReg[s][5:3] ==
        {$past(scaleIn[s].gzNet), $past(scaleIn[s].gzGross), $past(scaleIn[s].gzDisp)})
      else $error("good zero bits wrong");
    // Mode and motion follow both ways, not only on entry to net mode
    a_mode_motion: assert property (
      $past(rst_n) |-> statusReg[s][7:6] ==
        {$past(scaleIn[s].motion), $past(scaleIn[s].netMode)})
      else $error("mode or motion bit wrong");
    a_flow_disp: assert property (
      $past(rst_n) |->
        statusReg[s][`SSRB_BIT_FLOWDISP] == $past(scaleIn[s].flowShown))
      else $error("flow display bit wrong");
    a_net_prec: assert property (
      $past(rst_n) |->
        statusReg[s][`SSRB_BIT_NETPREC] == ssrbOver6($past(scaleIn[s].net)))
      else $error("net precision bit wrong");
    a_gross_prec: assert property (
      ssrbOver6(scaleIn[s].gross) |=> statusReg[s][`SSRB_BIT_GROSSPREC])
      else $error("gross precision bit missed");
    a_unused_zero: assert property (
      (statusReg[s] & `SSRB_UNUSED_MASK) == `SSRB_RESET_WORD)
      else $error("unused status bit set");
    a_gross_value: assert property (
      ssrbFits16(scaleIn[s].gross) |=> grossReg[s] == $past(scaleIn[s].gross[15:0]))
      else $error("gross value not presented");
  end

  // Analog output mirror, same snapshot timing as the scales
  for (genvar a = 0; a < `SSRB_NAOUT; a++) begin : g_aout
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        aoutReg[a] <= `SSRB_RESET_WORD;
      end else begin
        aoutReg[a] <= aoutVal[a];
      end
    end
  end

  // Address decode; reads return snapshots, writes are refused and
  // change nothing because the bank holds no writable state
  always_comb begin
    next_rsp       = '0;
    next_rsp.valid = req.valid;
    if (req.valid && req.write) begin
      next_rsp.err = 1'b1;
    end else if (req.valid && (req.addr < `SSRB_ANALOG_BASE)) begin
      // Scale block: index bits 5:3 pick the scale, 2:0 the field
      unique case (req.addr[2:0])
        `SSRB_OFF_STATUS: begin
          next_rsp.data = statusReg[req.addr[5:3]];
        end
        `SSRB_OFF_GROSS: begin
          next_rsp.data = grossReg[req.addr[5:3]];
        end
        `SSRB_OFF_NET: begin
          next_rsp.data = netReg[req.addr[5:3]];
        end
        `SSRB_OFF_FLOW: begin
          next_rsp.data = flowReg[req.addr[5:3]];
        end
        `SSRB_OFF_SIGNAL: begin
          next_rsp.data = sigReg[req.addr[5:3]];
        end
        `SSRB_OFF_ERROR: begin
          next_rsp.data = {8'h00, errReg[req.addr[5:3]]};
        end
        default: begin
          next_rsp.err = 1'b1; // Gap in the scale block
        end
      endcase
    end else if (req.valid && (req.addr[7:2] == 6'(`SSRB_ANALOG_BASE >> 2))) begin
      next_rsp.data = aoutReg[req.addr[1:0]];
    end else if (req.valid) begin
      // Digital input words; pin order already matches bit order
      case (req.addr)
        `SSRB_DIN_W0: begin
          next_rsp.data = digSync[15:0];
        end
        `SSRB_DIN_W1: begin
          next_rsp.data = digSync[31:16];
        end
        `SSRB_DIN_W2: begin
          next_rsp.data = digSync[47:32];
        end
        default: begin
          next_rsp.err = 1'b1; // Unmapped index
        end
      endcase
    end
  end

  // Answer register; data only ever comes from a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // A steady pin level reaches the read data after the sync chain
  sequence s_pin_steady;
    $stable(digIn[0]) [*3];
  endsequence
  sequence s_read_w0;
    req.valid && !req.write && req.addr == `SSRB_DIN_W0;
  endsequence
  a_din_first: assert property (
    s_pin_steady ##0 s_read_w0 |=> rsp.valid && rsp.data[0] == $past(digIn[0], 2))
    else $error("input word one bit wrong");
  a_din_second: assert property (
    req.valid && !req.write && req.addr == `SSRB_DIN_W1
      |=> rsp.data == $past(digSync[31:16]))
    else $error("input word two wrong");
  a_din_third: assert property (
    req.valid && !req.write && req.addr == `SSRB_DIN_W2
      |=> rsp.data == $past(digSync[47:32]))
    else $error("input word three wrong");
  // Writes get an error answer with zero data in the next cycle
  a_write_refused: assert property (
    req.valid && req.write |=> rsp.valid && rsp.err && rsp.data == 16'h0000)
    else $error("write not refused");
  a_aout_mirror: assert property (
    req.valid && !req.write && req.addr == `SSRB_ANALOG_BASE
      |=> rsp.data == $past(aoutReg[0]))
    else $error("analog mirror wrong");
  a_err_range: assert property (
    req.valid && !req.write && req.addr[2:0] == `SSRB_OFF_ERROR
      && req.addr < `SSRB_ANALOG_BASE |=> rsp.data[15:8] == 8'h00)
    else $error("error code out of range");
  a_rsp_timing: assert property (
    !req.valid |=> !rsp.valid)
    else $error("answer without request");
endmodule // ssrb_bank
`default_nettype wire

// file: dv/ssrb_master_model.sv
// Register-reading master model standing in front of the scale status bank
`timescale 1ns/1ps
`default_nettype none
module ssrb_master_model (
  input  wire logic                clk, // Bank clock
  output var  ssrb_pkg::ssrb_req_t req, // Request to the bank
  input  wire ssrb_pkg::ssrb_rsp_t rsp  // Answer from the bank
);
  import ssrb_pkg::*;
  // Idle request at time zero
  initial begin
    req = '0;
  end
  // One request per call; the answer stands only in the cycle after the taking edge
  task automatic transact(input logic [7:0] a, input logic wr, output logic [15:0] dt,
                          output logic er, output logic vl);
    @(negedge clk);
    req = '{valid: 1'b1, write: wr, addr: a};
    @(negedge clk);
    // Released address shows its inverse so a stale index cannot pass unseen
    req = '{valid: 1'b0, write: 1'b0, addr: ~a};
    vl = rsp.valid;
    er = rsp.err;
    dt = rsp.data;
  endtask
  // A value is never taken alone: status and error code are read with it
  task automatic read_group(input int s, input logic [2:0] off, output logic [15:0] st,
                            output logic [15:0] ec, output logic [15:0] val,
                            output logic ok);
    logic er;
    logic vl;
    transact(8'(8 * s), 1'b0, st, er, vl);
    transact(8'(8 * s) + 8'(`SSRB_OFF_ERROR), 1'b0, ec, er, vl);
    transact(8'(8 * s) + 8'(off), 1'b0, val, er, vl);
    ok = vl & ~er & (ec == 16'h0000);
  endtask
endmodule // ssrb_master_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the scale status bank
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_regs.svh"
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin failCount++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module testbench;
  import ssrb_pkg::*;
  logic        clk;                     // 100 MHz clock
  logic        rst_n;                   // Sync reset, low
  ssrb_scale_t scaleIn [`SSRB_NSCALE];  // Live scale data
  logic [15:0] aoutVal [`SSRB_NAOUT];   // Analog output values
  logic [47:0] digIn;                   // Digital input pins
  ssrb_req_t   req;                     // Request from the master model
  ssrb_rsp_t   rsp;                     // Answer of the bank
  int          failCount;               // Mismatches
  int          nTests;                  // Comparisons

  ssrb_bank DUT (.clk(clk), .rst_n(rst_n), .scaleIn(scaleIn), .aoutVal(aoutVal),
                 .digIn(digIn), .req(req), .rsp(rsp));
  ssrb_master_model master (.clk(clk), .req(req), .rsp(rsp));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Signed 16-bit range is what one register holds
  function automatic logic fits(input logic signed [31:0] x);
    return (x <= 32767) && (x >= -32768);
  endfunction
  // Beyond six digits either way
  function automatic logic big(input logic signed [31:0] x);
    return (x > 999999) || (x < -999999);
  endfunction
  // Saturated register image of a wide value
  function automatic logic [15:0] sat16(input logic signed [31:0] x);
    if (x > 32767) return 16'h7fff;
    if (x < -32768) return 16'h8000;
    return x[15:0];
  endfunction
  // Status word worked out bit by bit; unused bits stay zero
  function automatic logic [15:0] expStat(input ssrb_scale_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[2:0] = {!fits(c.flow), !fits(c.gross), !fits(c.net)};
    w[7:3] = {c.motion, c.netMode, c.gzNet, c.gzGross, c.gzDisp};
    w[11] = c.flowShown;
    w[13:12] = {big(c.gross), big(c.net)};
    return w;
  endfunction

  // One access judged as {valid, err, data}
  task automatic expectReg(input logic [7:0] a, input logic wr, input logic [16:0] ex);
    logic [15:0] dt;
    logic er;
    logic vl;
    master.transact(a, wr, dt, er, vl);
    `CHK("answer", {1'b1, ex}, {vl, er, dt})
  endtask

  // Load one scale, then read its status, error code, gross, net and flow through grouped reads, and its input signal alone
  task automatic t_scale(input int s, input int n, input int g, input int f,
                         input logic [5:0] fl, input logic [7:0] ec);
    ssrb_scale_t c;
    logic [15:0] st;
    logic [15:0] ecd;
    logic [15:0] val;
    logic ok;
    c = '{net: n, gross: g, flow: f, inSignal: 16'h1234 + 16'(s), errCode: ec,
          gzDisp: fl[0], gzGross: fl[1], gzNet: fl[2], netMode: fl[3], motion: fl[4],
          flowShown: fl[5]};
    @(negedge clk);
    scaleIn[s] = c;
    repeat (2) @(negedge clk);
    master.read_group(s, `SSRB_OFF_GROSS, st, ecd, val, ok);
    `CHK("status", expStat(c), st)
    `CHK("error code", {8'h00, ec}, ecd)
    `CHK("gross", {ec == 8'h00, sat16(c.gross)}, {ok, val})
    master.read_group(s, `SSRB_OFF_NET, st, ecd, val, ok);
    `CHK("net", {ec == 8'h00, sat16(c.net)}, {ok, val})
    master.read_group(s, `SSRB_OFF_FLOW, st, ecd, val, ok);
    `CHK("flow", {ec == 8'h00, sat16(c.flow)}, {ok, val})
    expectReg(8'(8 * s) + 8'(`SSRB_OFF_SIGNAL), 1'b0, {1'b0, c.inSignal});
  endtask

  // Writes and unmapped indices are refused and change nothing
  task automatic t_refuse();
    expectReg(8'h18, 1'b1, 17'h10000);
    expectReg(8'h18, 1'b0, {1'b0, expStat(scaleIn[3])});
    expectReg(8'h06, 1'b0, 17'h10000);
    expectReg(8'h47, 1'b0, 17'h10000);
    expectReg(8'hff, 1'b0, 17'h10000);
  endtask

  // Analog mirrors and the three input words, each pattern and its inverse
  task automatic t_mirrors(input logic [47:0] pat);
    @(negedge clk);
    digIn = pat;
    for (int i = 0; i < `SSRB_NAOUT; i++) aoutVal[i] = pat[15:0] + 16'(i * 16'h0111);
    repeat (4) @(negedge clk);
    for (int i = 0; i < `SSRB_NAOUT; i++) begin
      expectReg(`SSRB_ANALOG_BASE + 8'(i), 1'b0, {1'b0, aoutVal[i]});
    end
    expectReg(`SSRB_DIN_W0, 1'b0, {1'b0, pat[15:0]});
    expectReg(`SSRB_DIN_W1, 1'b0, {1'b0, pat[31:16]});
    expectReg(`SSRB_DIN_W2, 1'b0, {1'b0, pat[47:32]});
  endtask

  // Counts, verdict and end of run
  task automatic printVerdict();
    $display("comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    failCount++;
    printVerdict();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    digIn = '0;
    foreach (scaleIn[i]) scaleIn[i] = '0;
    foreach (aoutVal[i]) aoutVal[i] = 16'h0000;
    repeat (16) @(negedge clk);
    `CHK("reset answer", ssrb_rsp_t'(0), rsp)
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_scale(0, 32767, -32768, 0, 6'h00, 8'h00);
    t_scale(3, 32768, -32769, 40000, 6'h3f, 8'h00);
    t_scale(7, 1000000, -999999, -40000, 6'h15, 8'hff);
    t_scale(5, -1000000, 1000000, -32769, 6'h2a, 8'h03);
    t_refuse();
    t_mirrors(48'h0123_4567_89ab);
    t_mirrors(48'hfedc_ba98_7654);
    printVerdict();
  end
endmodule // testbench
`default_nettype wire
